// ---- hw/plcr_pkg.sv ----
// plcr_pkg: constants for the link capabilities register bank
// assumes: nothing beyond standard SystemVerilog
package plcr_pkg;
  localparam logic [7:0] LINK_CAP_OFFSET   = 8'h78;
  localparam int         PORT_LO           = 24;
  localparam int         PORT_HI           = 31;
  localparam int         RSVD_LO           = 18;
  localparam int         RSVD_HI           = 23;
  localparam logic [2:0] DEEP_WAKE_CODE    = 3'h7;
  localparam logic [2:0] STANDBY_WAKE_CODE = 3'h7;
  localparam logic [1:0] ASPM_L0S_ONLY     = 2'h1;
  localparam logic [5:0] LANES_X1          = 6'h01;
  localparam logic [5:0] LANES_X4          = 6'h04;
  localparam logic [5:0] LANES_X8          = 6'h08;
  localparam logic [5:0] LANES_X16         = 6'h10;
  localparam logic [3:0] RATE_2G5          = 4'h1;
  localparam int         PORT_COUNT        = 8;
endpackage

// ---- hw/plcr_cfg_if.sv ----
// plcr_cfg_if: configuration access carrier between decoder and bank
// assumes: one clock domain
`timescale 1ns/100ps
interface plcr_cfg_if;
  logic [2:0]  port_sel;
  logic        wr;
  logic [3:0]  be;
  logic [31:0] wdata;
  modport master (output port_sel, output wr, output be, output wdata);
  modport slave  (input port_sel, input wr, input be, input wdata);
endinterface

// ---- hw/plcr_port_bank.sv ----
// plcr_port_bank: per-port write-once port index field
// assumes: decoder presents one-cycle write strobes with byte enables
`timescale 1ns/100ps
module plcr_port_bank (
  input  wire logic        clk,
  input  wire logic        rst,
  plcr_cfg_if.slave        cfg,
  output logic [63:0]      port_index_flat
);
  logic [7:0] written;
  genvar g;
  generate
    for (g = 0; g < plcr_pkg::PORT_COUNT; g++) begin : g_port
      // field written once, then frozen until reset
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          port_index_flat[g*8 +: 8] <= 8'(g);
          written[g]                <= 1'b0;
        end else if (cfg.wr && cfg.be[3] && cfg.port_sel == 3'(g) && !written[g]) begin
          port_index_flat[g*8 +: 8] <= cfg.wdata[plcr_pkg::PORT_HI:plcr_pkg::PORT_LO];
          written[g]                <= 1'b1;
        end
      end
    end
  endgenerate
endmodule

// ---- hw/plcr_link_cap.sv ----
// plcr_link_cap: link capabilities register for each root port
// assumes: config access port gives port number, offset, strobes; one clock
//
// Contract
// - port index bits 31:24 write once, reset to the port's device number
// - deep sleep wake latency bits 17:15 fixed at 7h
// - standby wake latency bits 14:12 fixed at 7h
// - aspm support bits 11:10 read 01, L0s entry only
// - never start L0s on own transmit side; allow downstream to do so
// - max lane count bits 9:4 with x1/x4/x8/x16 codes
// - lane default per port: 0,1,3,5,7 x4; 2,6 x8; 4 x16
// - max signalling rate bits 3:0 read 0001, 2.5 Gb/s
// - merged link is controlled through lower-numbered port's registers
`timescale 1ns/100ps
module plcr_link_cap (
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic [2:0]  CFG_PORT,
  input  wire logic [7:0]  CFG_OFFSET,
  input  wire logic        CFG_RD,
  input  wire logic        CFG_WR,
  input  wire logic [3:0]  CFG_BE,
  input  wire logic [31:0] CFG_WDATA,
  input  wire logic [7:0]  MERGE_WITH_LOWER,
  output logic [31:0]      CFG_RDATA,
  output logic             CFG_RVALID,
  output logic             TX_STANDBY_ENTRY_EN
);
  localparam int IDX_W  = plcr_pkg::PORT_HI - plcr_pkg::PORT_LO + 1;
  localparam int RSVD_W = plcr_pkg::RSVD_HI - plcr_pkg::RSVD_LO + 1;
  localparam int LANE_W = 6;
  localparam int SEL_W  = 3;
  localparam int NPORT  = plcr_pkg::PORT_COUNT;

  plcr_cfg_if              cfg ();
  logic [NPORT*IDX_W-1:0]  port_index_flat;
  logic [SEL_W-1:0]        eff_port;
  logic [NPORT*SEL_W-1:0]  owner_flat;
  logic [NPORT-1:0]        merge_s1;
  logic [NPORT-1:0]        merge_s2;
  logic [NPORT-1:0]        merge_s3;
  logic [NPORT-1:0]        merge_q;
  logic [NPORT*LANE_W-1:0] lanes_flat;
  logic                    cap_hit_rd;
  logic                    cap_hit_wr;
  logic [IDX_W-1:0]        port_index_field;
  logic [RSVD_W-1:0]       rsvd_field;
  logic [2:0]              deep_sleep_wake_latency;
  logic [2:0]              standby_wake_latency;
  logic [1:0]              aspm_support_level;
  logic [LANE_W-1:0]       max_lane_count;
  logic [3:0]              max_signalling_rate;
  logic [31:0]             next_rdata;
  genvar                   m;
  genvar                   l;
  genvar                   o;

  ////////////////////////////////////////////////////////////////////////
  // lane count default per port instance
  function automatic logic [5:0] lanes_for(input logic [2:0] p);
    case (p)
      3'h0:    lanes_for = plcr_pkg::LANES_X4;
      3'h1:    lanes_for = plcr_pkg::LANES_X4;
      3'h2:    lanes_for = plcr_pkg::LANES_X8;
      3'h3:    lanes_for = plcr_pkg::LANES_X4;
      3'h4:    lanes_for = plcr_pkg::LANES_X16;
      3'h5:    lanes_for = plcr_pkg::LANES_X4;
      3'h6:    lanes_for = plcr_pkg::LANES_X8;
      3'h7:    lanes_for = plcr_pkg::LANES_X4;
      default: lanes_for = plcr_pkg::LANES_X4;
    endcase
  endfunction

  // true when an access addresses this register
  function automatic logic is_cap_offset(input logic [7:0] off);
    is_cap_offset = (off == plcr_pkg::LINK_CAP_OFFSET);
  endfunction

  // follow merges downward until an unmerged port or port 0 owns the link
  function automatic logic [2:0] route_port(input logic [2:0] p, input logic [7:0] merged);
    route_port = p;
    for (int i = 0; i < plcr_pkg::PORT_COUNT - 1; i++) begin
      if (merged[route_port] && route_port != 3'h0) begin
        route_port = route_port - 3'h1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // merge straps come from pins: three stages, taken once two and three agree
  generate
    for (m = 0; m < NPORT; m++) begin : g_merge
      always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
          merge_s1[m] <= 1'b0;
          merge_s2[m] <= 1'b0;
          merge_s3[m] <= 1'b0;
        end else begin
          merge_s1[m] <= MERGE_WITH_LOWER[m];
          merge_s2[m] <= merge_s1[m];
          merge_s3[m] <= merge_s2[m];
        end
      end

      always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
          merge_q[m] <= 1'b0;
        end else if (merge_s2[m] == merge_s3[m]) begin
          merge_q[m] <= merge_s3[m];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // lane defaults and owning port laid out per port
  generate
    for (l = 0; l < NPORT; l++) begin : g_lanes
      assign lanes_flat[l*LANE_W +: LANE_W] = lanes_for(SEL_W'(l));
    end
  endgenerate

  generate
    for (o = 0; o < NPORT; o++) begin : g_owner
      assign owner_flat[o*SEL_W +: SEL_W] = route_port(SEL_W'(o), merge_q);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // request decode and routing
  assign eff_port   = owner_flat[CFG_PORT*SEL_W +: SEL_W];
  assign cap_hit_rd = CFG_RD && is_cap_offset(CFG_OFFSET);
  assign cap_hit_wr = CFG_WR && is_cap_offset(CFG_OFFSET);

  assign cfg.port_sel = eff_port;
  assign cfg.wr       = cap_hit_wr;
  assign cfg.be       = CFG_BE;
  assign cfg.wdata    = CFG_WDATA;

  plcr_port_bank u_bank (
    .clk             (CLK_SYS),
    .rst             (SYS_RST),
    .cfg             (cfg),
    .port_index_flat (port_index_flat)
  );

  ////////////////////////////////////////////////////////////////////////
  // field views of the addressed port
  always_comb begin
    port_index_field        = port_index_flat[eff_port*IDX_W +: IDX_W];
    rsvd_field              = '0;
    deep_sleep_wake_latency = plcr_pkg::DEEP_WAKE_CODE;
    standby_wake_latency    = plcr_pkg::STANDBY_WAKE_CODE;
    aspm_support_level      = plcr_pkg::ASPM_L0S_ONLY;
    max_lane_count          = lanes_flat[eff_port*LANE_W +: LANE_W];
    max_signalling_rate     = plcr_pkg::RATE_2G5;
  end

  ////////////////////////////////////////////////////////////////////////
  // read word; other offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (cap_hit_rd) begin
      next_rdata = {port_index_field,
                    rsvd_field,
                    deep_sleep_wake_latency,
                    standby_wake_latency,
                    aspm_support_level,
                    max_lane_count,
                    max_signalling_rate};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data holds until the next read
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      CFG_RDATA <= 32'h0000_0000;
    end else if (CFG_RD) begin
      CFG_RDATA <= next_rdata;
    end
  end

  // one answer pulse per read request
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      CFG_RVALID <= 1'b0;
    end else begin
      CFG_RVALID <= CFG_RD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // own transmitter never requests standby; receive side is unaffected
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      TX_STANDBY_ENTRY_EN <= 1'b0;
    end else begin
      TX_STANDBY_ENTRY_EN <= 1'b0;
    end
  end
endmodule

// ---- tb/plcr_link_cap_properties.sv ----
// plcr_link_cap_properties: port checks of the link capabilities bank
// assumes: bound to plcr_link_cap, one clock CLK_SYS
`timescale 1ns/100ps
module plcr_link_cap_properties (
  input wire logic        CLK_SYS,
  input wire logic        SYS_RST,
  input wire logic [7:0]  CFG_OFFSET,
  input wire logic        CFG_RD,
  input wire logic [31:0] CFG_RDATA,
  input wire logic        CFG_RVALID,
  input wire logic        TX_STANDBY_ENTRY_EN
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  sequence rd_cap;
    CFG_RD && CFG_OFFSET == 8'h78;
  endsequence
  AST_ANSWER: assert property (CFG_RD |=> CFG_RVALID) else $error("no answer");
  AST_NO_STRAY: assert property (!CFG_RD |=> !CFG_RVALID) else $error("stray answer");
  AST_TX_IDLE: assert property (!TX_STANDBY_ENTRY_EN) else $error("own standby");
  AST_DEEP: assert property (rd_cap |=> CFG_RDATA[17:15] == 3'h7) else $error("deep");
  AST_STBY: assert property (rd_cap |=> CFG_RDATA[14:12] == 3'h7) else $error("stby");
  AST_ASPM: assert property (rd_cap |=> CFG_RDATA[11:10] == 2'h1) else $error("aspm");
  AST_LANES: assert property (rd_cap |=> CFG_RDATA[9:4] inside {6'h04, 6'h08, 6'h10})
    else $error("lanes");
  AST_RATE: assert property (rd_cap |=> CFG_RDATA[3:0] == 4'h1) else $error("rate");
  AST_RSVD: assert property (rd_cap |=> CFG_RDATA[23:18] == 6'h00) else $error("rsvd");
  AST_HOLD: assert property (!CFG_RD |=> $stable(CFG_RDATA)) else $error("rdata moved");
endmodule
bind plcr_link_cap plcr_link_cap_properties i_props (.CLK_SYS, .SYS_RST, .CFG_OFFSET, .CFG_RD,
  .CFG_RDATA, .CFG_RVALID, .TX_STANDBY_ENTRY_EN);

// ---- tb/tb_plcr_link_cap.sv ----
// tb_plcr_link_cap: directed config reads and writes
// assumes: design and checker compiled before it
`timescale 1ns/100ps
module tb_plcr_link_cap;
  logic        CLK_SYS = 0, SYS_RST = 1, CFG_RD = 0, CFG_WR = 0, CFG_RVALID, TX_STANDBY_ENTRY_EN;
  logic [2:0]  CFG_PORT = 0;
  logic [3:0]  CFG_BE = 0;
  logic [7:0]  CFG_OFFSET = 0, MERGE_WITH_LOWER = 0;
  logic [31:0] CFG_WDATA = 0, CFG_RDATA;
  int          n_errors = 0, checked = 0;
  localparam logic [47:0] LANES = {6'h04, 6'h08, 6'h04, 6'h10, 6'h04, 6'h08, 6'h04, 6'h04};
  plcr_link_cap i_dut (.CLK_SYS, .SYS_RST, .CFG_PORT, .CFG_OFFSET, .CFG_RD, .CFG_WR, .CFG_BE,
    .CFG_WDATA, .MERGE_WITH_LOWER, .CFG_RDATA, .CFG_RVALID, .TX_STANDBY_ENTRY_EN);
  always #2 CLK_SYS = ~CLK_SYS;
  function logic [31:0] cap(input logic [7:0] idx, input logic [5:0] ln);
    return {idx, 6'h00, 3'h7, 3'h7, 2'h1, ln, 4'h1};
  endfunction
  task rd(input logic [2:0] p, input logic [7:0] o, input logic [31:0] e);
    @(posedge CLK_SYS);
    CFG_PORT <= p;
    CFG_OFFSET <= o;
    CFG_RD <= 1'b1;
    @(posedge CLK_SYS);
    CFG_RD <= 1'b0;
    #1;
    checked++;
    if (CFG_RVALID !== 1'b1 || CFG_RDATA !== e || TX_STANDBY_ENTRY_EN !== 1'b0) begin
      n_errors++;
      $display("BAD %0t port %0d read %h", $time, p, CFG_RDATA);
    end
  endtask
  task wr(input logic [2:0] p, input logic [3:0] b, input logic [31:0] d);
    @(posedge CLK_SYS);
    CFG_PORT <= p;
    CFG_OFFSET <= 8'h78;
    CFG_BE <= b;
    CFG_WDATA <= d;
    CFG_WR <= 1'b1;
    @(posedge CLK_SYS);
    CFG_WR <= 1'b0;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #4000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    for (int p = 0; p < 8; p++) rd(3'(p), 8'h78, cap(8'(p), LANES[p*6 +: 6]));
    $display("defaults done");
    wr(3'h2, 4'hF, 32'hAAFF_FFFF);
    rd(3'h2, 8'h78, cap(8'hAA, 6'h08));
    wr(3'h2, 4'hF, 32'h5500_0000);
    wr(3'h5, 4'h7, 32'h3300_0000);
    rd(3'h2, 8'h78, cap(8'hAA, 6'h08));
    rd(3'h5, 8'h78, cap(8'h05, 6'h04));
    rd(3'h5, 8'h7C, 32'h0000_0000);
    $display("write once done");
    @(posedge CLK_SYS) MERGE_WITH_LOWER <= 8'h08;
    repeat (6) @(posedge CLK_SYS);
    rd(3'h3, 8'h78, cap(8'hAA, 6'h08));
    $display("merge done");
    @(posedge CLK_SYS) SYS_RST <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    repeat (6) @(posedge CLK_SYS);
    rd(3'h2, 8'h78, cap(8'h02, 6'h08));
    wr(3'h3, 4'h8, 32'h7700_0000);
    rd(3'h2, 8'h78, cap(8'h77, 6'h08));
    $display("reset and merged write done");
    stop_test();
  end
endmodule
